// ### logic/acu_core.sv
/*
  accumulator command unit: axi4-lite slave that takes a nine-byte frame,
  executes accumulator transfers and x-register arithmetic, keeps coordinates.
  assumes axis and global parameter writes and nonvolatile writes are taken
  by the surroundings in the cycle they are pulsed, with no back-pressure.
*/
`timescale 1ns/1ps
`default_nettype none
module acu_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [acu_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [acu_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic ap_wr,
  output logic [1:0] ap_axis,
  output logic [7:0] ap_num,
  output logic [31:0] ap_data,
  output logic gp_wr,
  output logic [1:0] gp_bank,
  output logic [7:0] gp_num,
  output logic [31:0] gp_data,
  output logic nv_wr,
  output logic [1:0] nv_axis,
  output logic [4:0] nv_slot,
  output logic [31:0] nv_data
);
  import acu_pkg::*;

  function automatic logic [5:0] coord_index(input logic [1:0] ax, input logic [4:0] sl);
    return 6'(6'(ax) * 6'(NUM_SLOTS) + 6'(sl));
  endfunction

  acu_state_t state_q, state_d;
  logic [31:0] frame_q, value_q, accu_q, xreg_q, accu_d, xreg_d;
  logic [7:0] chk_q, status_q;
  logic persist_q, persist_d;
  logic aw_held_q, w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] cp_axis_q;
  logic [4:0] cp_slot_q, cp_lo_q, cp_hi_q;
  logic [31:0] coord_mem [0:63];

  acu_alu_if alu_bus ();
  acu_alu u_alu (
    .bus(alu_bus.alu)
  );
  logic sum_ok, addr_ok;
  acu_frame_chk u_chk (
    .frame(frame_q),
    .value(value_q),
    .checksum(chk_q),
    .own_addr(OWN_ADDR_RST),
    .sum_ok(sum_ok),
    .addr_ok(addr_ok)
  );

  // frame fields
  wire logic [7:0] f_code = frame_q[FRAME_CODE_LSB +: 8];
  wire logic [7:0] f_type = frame_q[FRAME_TYPE_LSB +: 8];
  wire logic [7:0] f_motor = frame_q[FRAME_MOTOR_LSB +: 8];
  wire logic idle = (state_q == ST_IDLE);
  wire logic motor_ok = (f_motor < NUM_AXES);
  wire logic slot_ok = (f_type <= MAX_SLOT);
  wire logic bank_ok = (f_motor == 8'h00) || (f_motor == 8'h02) || (f_motor == 8'h03);
  wire logic is_copy = (f_code == CODE_SET_COORD) && (f_motor == ALL_MOTORS) &&
                       (value_q == WORD_RST);
  wire logic is_coord = (f_code == CODE_TO_COORD) || ((f_code == CODE_SET_COORD) && !is_copy);
  wire logic [7:0] exec_st =
    !sum_ok ? ST_BAD_SUM :
    is_coord ? (!slot_ok ? ST_BAD_TYPE : (!motor_ok ? ST_BAD_VALUE : ST_OK)) :
    is_copy ? (slot_ok ? ST_OK : ST_BAD_TYPE) :
    (f_code == CODE_X_ARITH) ? ((f_type <= XOP_LAST) ? ST_OK : ST_BAD_TYPE) :
    (f_code == CODE_TO_AXIS) ? (motor_ok ? ST_OK : ST_BAD_VALUE) :
    (f_code == CODE_TO_GLOBAL) ? (bank_ok ? ST_OK : ST_BAD_VALUE) : ST_BAD_CMD;
  // frames for another target address pass without any answer
  wire logic exec_go = (state_q == ST_EXEC) && addr_ok && (exec_st == ST_OK);
  wire logic coord_we = exec_go && is_coord;
  wire logic [31:0] coord_wdata = (f_code == CODE_TO_COORD) ? accu_q : value_q;
  wire logic [5:0] coord_widx = coord_index(f_motor[1:0], f_type[4:0]);
  wire logic xop_go = exec_go && (f_code == CODE_X_ARITH);
  wire logic copy_go = exec_go && is_copy;
  wire logic copy_last = (cp_axis_q == 2'(NUM_AXES - 8'h01)) && (cp_slot_q == cp_hi_q);
  // slot zero never reaches nonvolatile storage
  wire logic nv_from_set = coord_we && persist_q && (f_type != 8'h00);
  wire logic [31:0] cp_word = coord_mem[coord_index(cp_axis_q, cp_slot_q)];

  // bus write side
  wire logic wr_fire = aw_held_q && w_held_q && !bvalid;
  wire logic [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire logic wr_idle = wr_fire && idle;
  wire logic wr_frame = wr_idle && (awaddr_q == REG_FRAME);
  wire logic wr_value = wr_idle && (awaddr_q == REG_VALUE);
  wire logic wr_launch = wr_idle && (awaddr_q == REG_LAUNCH);
  wire logic wr_accu = wr_idle && (awaddr_q == REG_ACCU);
  wire logic wr_xreg = wr_idle && (awaddr_q == REG_XREG);
  wire logic wr_config = wr_idle && (awaddr_q == REG_CONFIG);
  wire logic wr_known = (awaddr_q == REG_FRAME) || (awaddr_q == REG_VALUE) ||
                        (awaddr_q == REG_LAUNCH) || (awaddr_q == REG_STATUS) ||
                        (awaddr_q == REG_ACCU) || (awaddr_q == REG_XREG) ||
                        (awaddr_q == REG_CONFIG);
  wire logic [31:0] frame_wr = (frame_q & ~wmask) | (wdata_q & wmask);
  wire logic [31:0] value_wr = (value_q & ~wmask) | (wdata_q & wmask);
  wire logic [31:0] accu_wr = (accu_q & ~wmask) | (wdata_q & wmask);
  wire logic [31:0] xreg_wr = (xreg_q & ~wmask) | (wdata_q & wmask);

  // bus read side
  wire logic rd_fire = arvalid && arready;
  wire logic [31:0] status_word = {23'h000000, !idle, status_q};
  wire logic rd_known = (araddr == REG_FRAME) || (araddr == REG_VALUE) ||
                        (araddr == REG_LAUNCH) || (araddr == REG_STATUS) ||
                        (araddr == REG_ACCU) || (araddr == REG_XREG) || (araddr == REG_CONFIG);
  wire logic [31:0] rd_word =
    (araddr == REG_FRAME) ? frame_q :
    (araddr == REG_VALUE) ? value_q :
    (araddr == REG_LAUNCH) ? {24'h000000, chk_q} :
    (araddr == REG_STATUS) ? status_word :
    (araddr == REG_ACCU) ? accu_q :
    (araddr == REG_XREG) ? xreg_q :
    (araddr == REG_CONFIG) ? {31'h00000000, persist_q} : WORD_RST;

  assign alu_bus.op = f_type[3:0];
  assign alu_bus.accu = accu_q;
  assign alu_bus.xreg = xreg_q;
  assign accu_d = xop_go ? alu_bus.accu_res : (wr_accu ? accu_wr : accu_q);
  assign xreg_d = xop_go ? alu_bus.xreg_res : (wr_xreg ? xreg_wr : xreg_q);
  // persistence is global setting 84 of bank 0, also settable from software
  assign persist_d =
    (exec_go && (f_code == CODE_TO_GLOBAL) && (f_motor == 8'h00) && (f_type == GP_PERSIST)) ?
      (accu_q != WORD_RST) :
    (wr_config ? ((persist_q & ~wmask[CONFIG_PERSIST_BIT]) |
                  (wdata_q[CONFIG_PERSIST_BIT] & wmask[CONFIG_PERSIST_BIT])) : persist_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (wr_launch) state_d = ST_EXEC;
      ST_EXEC: state_d = copy_go ? ST_COPY : ST_IDLE;
      ST_COPY: if (copy_last) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // coordinate store has no reset; contents are undefined until written
  always_ff @(posedge aclk) begin
    if (coord_we) coord_mem[coord_widx] <= coord_wdata;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      frame_q <= WORD_RST;
      value_q <= WORD_RST;
      chk_q <= 8'h00;
      accu_q <= WORD_RST;
      xreg_q <= WORD_RST;
      status_q <= 8'h00;
      persist_q <= PERSIST_RST;
    end else begin
      state_q <= state_d;
      accu_q <= accu_d;
      xreg_q <= xreg_d;
      persist_q <= persist_d;
      if (wr_frame) frame_q <= frame_wr;
      if (wr_value) value_q <= value_wr;
      if (wr_launch) chk_q <= wdata_q[7:0];
      if ((state_q == ST_EXEC) && addr_ok) status_q <= exec_st;
    end
  end

  // copy walker: slots lo..hi for every axis, one nonvolatile write a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cp_axis_q <= 2'h0;
      cp_slot_q <= 5'h00;
      cp_lo_q <= 5'h00;
      cp_hi_q <= 5'h00;
    end else if (copy_go) begin
      cp_axis_q <= 2'h0;
      cp_slot_q <= (f_type == 8'h00) ? 5'h01 : f_type[4:0];
      cp_lo_q <= (f_type == 8'h00) ? 5'h01 : f_type[4:0];
      cp_hi_q <= (f_type == 8'h00) ? MAX_SLOT[4:0] : f_type[4:0];
    end else if (state_q == ST_COPY) begin
      cp_slot_q <= (cp_slot_q == cp_hi_q) ? cp_lo_q : 5'(cp_slot_q + 5'h01);
      if (cp_slot_q == cp_hi_q) cp_axis_q <= 2'(cp_axis_q + 2'h1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ap_wr <= 1'b0;
      ap_axis <= 2'h0;
      ap_num <= 8'h00;
      ap_data <= WORD_RST;
      gp_wr <= 1'b0;
      gp_bank <= 2'h0;
      gp_num <= 8'h00;
      gp_data <= WORD_RST;
      nv_wr <= 1'b0;
      nv_axis <= 2'h0;
      nv_slot <= 5'h00;
      nv_data <= WORD_RST;
    end else begin
      ap_wr <= exec_go && (f_code == CODE_TO_AXIS);
      ap_axis <= f_motor[1:0];
      ap_num <= f_type;
      ap_data <= accu_q;
      gp_wr <= exec_go && (f_code == CODE_TO_GLOBAL);
      gp_bank <= f_motor[1:0];
      gp_num <= f_type;
      gp_data <= accu_q;
      nv_wr <= nv_from_set || (state_q == ST_COPY);
      nv_axis <= (state_q == ST_COPY) ? cp_axis_q : f_motor[1:0];
      nv_slot <= (state_q == ST_COPY) ? cp_slot_q : f_type[4:0];
      nv_data <= (state_q == ST_COPY) ? cp_word : coord_wdata;
    end
  end

  // axi4-lite: address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= WORD_RST;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_held_q <= 1'b1;
        awaddr_q <= {awaddr[ADDR_W-1:2], 2'h0};
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_held_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= WORD_RST;
      rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  a_launch_exec: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_launch |=> (state_q == ST_EXEC) ##1 (state_q != ST_EXEC))
    else $error("launch did not run exactly one execute cycle");
  a_coord_store: assert property (@(posedge aclk) disable iff (!aresetn)
    (coord_we && (f_code == CODE_TO_COORD)) |=> (coord_mem[$past(coord_widx)] == $past(accu_q)))
    else $error("coordinate slot does not hold the accumulator");
  a_persist_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (coord_we && !persist_q) |=> !nv_wr)
    else $error("nonvolatile write while persistence is off");
  a_slot_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    nv_wr |-> (nv_slot != 5'h00))
    else $error("slot zero sent to nonvolatile storage");
  a_reset_volatile: assert property (@(posedge aclk)
    !aresetn |=> !persist_q)
    else $error("persistence set after reset");
  a_xop_result: assert property (@(posedge aclk) disable iff (!aresetn)
    xop_go |=> (accu_q == $past(alu_bus.accu_res)) && (xreg_q == $past(alu_bus.xreg_res)))
    else $error("arithmetic result not committed");
  a_load_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
    (xop_go && (f_type == 8'h09)) |=> (xreg_q == $past(accu_q)) && $stable(accu_q))
    else $error("load changed accumulator or missed x");
  a_swap_both: assert property (@(posedge aclk) disable iff (!aresetn)
    (xop_go && (f_type == 8'h0A)) |=> (xreg_q == $past(accu_q)) && (accu_q == $past(xreg_q)))
    else $error("swap incomplete");
  a_axis_data: assert property (@(posedge aclk) disable iff (!aresetn)
    ap_wr |-> (ap_data == $past(accu_q)) && (ap_axis < 2'h3) && $past(state_q == ST_EXEC))
    else $error("axis parameter write wrong");
  a_bank_valid: assert property (@(posedge aclk) disable iff (!aresetn)
    gp_wr |-> (gp_bank != 2'h1) && (gp_data == $past(accu_q)))
    else $error("global parameter write to bad bank");
  a_copy_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (copy_go && (f_type == 8'h00)) |=> ##1 nv_wr[*8])
    else $error("copy-all stalled");
  a_ok_status: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_go |=> (status_q == ST_OK))
    else $error("successful command not answered with 100");
  c_copy_all: cover property (@(posedge aclk) disable iff (!aresetn)
    copy_go && (f_type == 8'h00));
  c_swap: cover property (@(posedge aclk) disable iff (!aresetn)
    xop_go && (f_type == 8'h0A));
  c_global: cover property (@(posedge aclk) disable iff (!aresetn) gp_wr);
  c_persist_nv: cover property (@(posedge aclk) disable iff (!aresetn) nv_from_set);
endmodule
`default_nettype wire

// ### logic/acu_pkg.sv
/*
  constants, types and field layout for the accumulator command unit.
  assumes one 200 MHz clock and an axi4-lite register port of 32-bit words.
*/
// Operation
// - code 39 copies accumulator into coordinate slot type of axis motor
// - config persistence bit chooses volatile only or also nonvolatile copies
// - slot zero is never written to nonvolatile storage
// - after reset coordinates are volatile only
// - code 33 runs operation type on accumulator and x register
// - arithmetic and logic results go back into the accumulator
// - types 0..4 are add, subtract, multiply, divide, modulo
// - types 5..7 are and, or, xor; type 8 inverts x
// - type 9 copies accumulator into x, accumulator unchanged
// - type 10 swaps accumulator and x in one step
// - code 34 writes accumulator to axis parameter type of axis motor
// - code 35 writes accumulator to global parameter type of bank 0, 2 or 3
// - set-coordinate with motor 255 and value 0 copies slot type, or slots 1..20 for type 0, to nonvolatile
package acu_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_FRAME = 12'h000;
  localparam logic [ADDR_W-1:0] REG_VALUE = 12'h004;
  localparam logic [ADDR_W-1:0] REG_LAUNCH = 12'h008;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_ACCU = 12'h010;
  localparam logic [ADDR_W-1:0] REG_XREG = 12'h014;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 12'h018;
  localparam int FRAME_ADDR_LSB = 24;
  localparam int FRAME_CODE_LSB = 16;
  localparam int FRAME_TYPE_LSB = 8;
  localparam int FRAME_MOTOR_LSB = 0;
  localparam int STATUS_BUSY_BIT = 8;
  localparam int CONFIG_PERSIST_BIT = 0;
  localparam logic PERSIST_RST = 1'b0;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  localparam logic [7:0] OWN_ADDR_RST = 8'h01;
  localparam logic [7:0] CODE_SET_COORD = 8'h1E;
  localparam logic [7:0] CODE_X_ARITH = 8'h21;
  localparam logic [7:0] CODE_TO_AXIS = 8'h22;
  localparam logic [7:0] CODE_TO_GLOBAL = 8'h23;
  localparam logic [7:0] CODE_TO_COORD = 8'h27;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] NUM_AXES = 8'h03;
  localparam logic [7:0] MAX_SLOT = 8'h14;
  localparam int NUM_SLOTS = 21;
  localparam logic [7:0] ALL_MOTORS = 8'hFF;
  localparam logic [7:0] GP_PERSIST = 8'h54;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    XOP_ADD = 4'h0, XOP_SUB = 4'h1, XOP_MUL = 4'h2, XOP_DIV = 4'h3,
    XOP_MOD = 4'h4, XOP_AND = 4'h5, XOP_OR = 4'h6, XOP_XOR = 4'h7,
    XOP_NOT = 4'h8, XOP_LOAD = 4'h9, XOP_SWAP = 4'hA
  } acu_xop_t;
  localparam logic [7:0] XOP_LAST = 8'h0A;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_EXEC = 3'b010, ST_COPY = 3'b100
  } acu_state_t;
endpackage

// ### logic/acu_alu_if.sv
/*
  carrier between the command core and the x-register arithmetic unit.
  assumes the core drives operands and reads results in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
interface acu_alu_if;
  logic [3:0] op;
  logic [31:0] accu;
  logic [31:0] xreg;
  logic [31:0] accu_res;
  logic [31:0] xreg_res;
  modport core (output op, output accu, output xreg, input accu_res, input xreg_res);
  modport alu (input op, input accu, input xreg, output accu_res, output xreg_res);
endinterface
`default_nettype wire

// ### logic/acu_alu.sv
/*
  combinational x-register arithmetic for the accumulator command unit.
  assumes the core only commits results for types 0..10.
*/
`timescale 1ns/1ps
`default_nettype none
module acu_alu (
  acu_alu_if.alu bus
);
  import acu_pkg::*;
  logic [63:0] product;
  logic x_zero;
  logic signed [31:0] quot, rem;
  assign product = $signed(bus.accu) * $signed(bus.xreg);
  // kept apart: inside the mux below they would turn unsigned
  assign quot = $signed(bus.accu) / $signed(bus.xreg);
  assign rem = $signed(bus.accu) % $signed(bus.xreg);
  assign x_zero = (bus.xreg == WORD_RST);
  always_comb begin
    bus.accu_res = bus.accu;
    bus.xreg_res = bus.xreg;
    case (bus.op)
      XOP_ADD: bus.accu_res = bus.accu + bus.xreg;
      XOP_SUB: bus.accu_res = bus.accu - bus.xreg;
      XOP_MUL: bus.accu_res = product[31:0];
      // divide by zero leaves the accumulator as it was
      XOP_DIV: bus.accu_res = x_zero ? bus.accu : quot;
      XOP_MOD: bus.accu_res = x_zero ? bus.accu : rem;
      XOP_AND: bus.accu_res = bus.accu & bus.xreg;
      XOP_OR: bus.accu_res = bus.accu | bus.xreg;
      XOP_XOR: bus.accu_res = bus.accu ^ bus.xreg;
      XOP_NOT: bus.accu_res = ~bus.xreg;
      XOP_LOAD: bus.xreg_res = bus.accu;
      XOP_SWAP: begin
        bus.accu_res = bus.xreg;
        bus.xreg_res = bus.accu;
      end
      default: bus.accu_res = bus.accu;
    endcase
  end
endmodule
`default_nettype wire

// ### logic/acu_frame_chk.sv
/*
  frame checks: modulo-256 checksum over eight bytes and target address match.
  assumes frame word holds address, code, type, motor from msb down.
*/
`timescale 1ns/1ps
`default_nettype none
module acu_frame_chk (
  input wire logic [31:0] frame,
  input wire logic [31:0] value,
  input wire logic [7:0] checksum,
  input wire logic [7:0] own_addr,
  output logic sum_ok,
  output logic addr_ok
);
  import acu_pkg::*;
  function automatic logic [7:0] byte_sum(input logic [31:0] a, input logic [31:0] b);
    return a[31:24] + a[23:16] + a[15:8] + a[7:0] + b[31:24] + b[23:16] + b[15:8] + b[7:0];
  endfunction
  assign sum_ok = (byte_sum(frame, value) == checksum);
  assign addr_ok = (frame[FRAME_ADDR_LSB +: 8] == own_addr);
endmodule
`default_nettype wire

// ### sim/acu_param_sink.sv
/*
  far-side model: takes axis, global and nonvolatile writes of the command unit.
  assumes each pulse qualifies its data for one cycle, with no back-pressure.
*/
`timescale 1ns/1ps
`default_nettype none
module acu_param_sink (
  input wire logic aclk,
  input wire logic ap_wr,
  input wire logic [1:0] ap_axis,
  input wire logic [7:0] ap_num,
  input wire logic [31:0] ap_data,
  input wire logic gp_wr,
  input wire logic [1:0] gp_bank,
  input wire logic [7:0] gp_num,
  input wire logic [31:0] gp_data,
  input wire logic nv_wr,
  input wire logic [1:0] nv_axis,
  input wire logic [4:0] nv_slot,
  input wire logic [31:0] nv_data
);
  // last word of each kind, kept for the bench to compare
  logic [41:0] ap_last = '0;
  logic [41:0] gp_last = '0;
  logic [38:0] nv_last = '0;
  int nv_cnt = 0;
  int nv_zero = 0;
  // always ready: the unit has no way to be stalled here
  always @(posedge aclk) begin
    if (ap_wr === 1'b1) ap_last <= {ap_axis, ap_num, ap_data};
    if (gp_wr === 1'b1) gp_last <= {gp_bank, gp_num, gp_data};
    if (nv_wr === 1'b1) begin
      nv_last <= {nv_axis, nv_slot, nv_data};
      nv_cnt <= nv_cnt + 1;
      if (nv_slot == 5'h00) nv_zero <= nv_zero + 1;
    end
  end
endmodule
`default_nettype wire

// ### sim/accumulator_command_unit_test.sv
/*
  self-checking bench: drives frames over axi4-lite, checks results and far-side writes.
  assumes acu_core and acu_param_sink; one 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module accumulator_command_unit_test;
  import acu_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  // responses are always accepted at once
  logic bready = 1'b1, rready = 1'b1;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, ap_wr, gp_wr, nv_wr;
  logic [1:0] bresp, rresp, ap_axis, gp_bank, nv_axis, rsp, wsp;
  logic [7:0] ap_num, gp_num;
  logic [4:0] nv_slot;
  logic [31:0] rdata, ap_data, gp_data, nv_data, rd, acc, xr, ea, ex;
  logic [41:0] ge;
  int bad_count = 0;
  int checks_done = 0;
  acu_core acu_core_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .ap_wr, .ap_axis, .ap_num, .ap_data, .gp_wr, .gp_bank,
    .gp_num, .gp_data, .nv_wr, .nv_axis, .nv_slot, .nv_data);
  acu_param_sink acu_param_sink_inst (.aclk, .ap_wr, .ap_axis, .ap_num, .ap_data, .gp_wr,
    .gp_bank, .gp_num, .gp_data, .nv_wr, .nv_axis, .nv_slot, .nv_data);
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task automatic complete_run;
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [43:0] seen, input logic [43:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wsp = bresp;
  endtask
  task automatic axi_rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
  endtask
  // sends one frame, waits for busy to drop; err spoils the checksum
  task automatic frame(input logic [7:0] c, t, m, input logic [31:0] v, input logic [7:0] err);
    logic [7:0] s;
    int n;
    s = OWN_ADDR_RST + c + t + m + v[31:24] + v[23:16] + v[15:8] + v[7:0] + err;
    n = 0;
    axi_wr(REG_FRAME, {OWN_ADDR_RST, c, t, m});
    axi_wr(REG_VALUE, v);
    axi_wr(REG_LAUNCH, {24'h0, s});
    do begin
      axi_rd(REG_STATUS);
      n++;
    end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 100);
    chk("busy clear", rd[STATUS_BUSY_BIT], 1'b0);
  endtask
  // zero divisor leaves the accumulator as it was
  function automatic void immediate_arith(input logic [3:0] op, input logic [31:0] a, x,
    output logic [31:0] na, nx);
    na = a;
    nx = x;
    case (op)
      0: na = a + x;
      1: na = a - x;
      2: na = a * x;
      3: if (x != 0) na = $signed(a) / $signed(x);
      4: if (x != 0) na = $signed(a) % $signed(x);
      5: na = a & x;
      6: na = a | x;
      7: na = a ^ x;
      8: na = ~x;
      9: nx = a;
      default: begin
        na = x;
        nx = a;
      end
    endcase
  endfunction
  initial begin
    repeat (50000) @(posedge aclk);
    bad_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h173a));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(REG_CONFIG);
    chk("persist reset", rd, 0);
    axi_rd(12'hFFC);
    chk("unmapped", rsp, RESP_SLVERR);
    axi_wr(12'hFFC, 32'h0);
    chk("unmapped write", wsp, RESP_SLVERR);
    // frames stand in for a stored program's run
    for (int i = 0; i < 33; i++) begin
      acc = $urandom();
      xr = (i < 11) ? 32'h0 : $urandom();
      axi_wr(REG_ACCU, acc);
      axi_wr(REG_XREG, xr);
      frame(CODE_X_ARITH, 8'(i % 11), 8'h00, 32'h0, 8'h00);
      immediate_arith(4'(i % 11), acc, xr, ea, ex);
      chk("xop status", rd[7:0], ST_OK);
      axi_rd(REG_ACCU);
      chk("accu", rd, ea);
      axi_rd(REG_XREG);
      chk("xreg", rd, ex);
    end
    for (int i = 0; i < 6; i++) begin
      acc = $urandom();
      axi_wr(REG_ACCU, acc);
      frame(CODE_TO_AXIS, 8'(i * 40), 8'(i % 3), $urandom(), 8'h00);
      chk("axis param", acu_param_sink_inst.ap_last, {2'(i % 3), 8'(i * 40), acc});
    end
    for (int i = 0; i < 4; i++) begin
      acc = $urandom();
      axi_wr(REG_ACCU, acc);
      frame(CODE_TO_GLOBAL, 8'h2A, 8'(i), 32'h0, 8'h00);
      if (i != 1) ge = {2'(i), 8'h2A, acc};
      chk("global param", acu_param_sink_inst.gp_last, ge);
      chk("bank status", rd[7:0], (i == 1) ? ST_BAD_VALUE : ST_OK);
    end
    acc = 32'h1234ABCD;
    axi_wr(REG_ACCU, acc);
    frame(CODE_TO_COORD, 8'h05, 8'h01, 32'h0, 8'h00);
    chk("coord status", rd[7:0], ST_OK);
    chk("volatile only", acu_param_sink_inst.nv_cnt, 0);
    axi_wr(REG_ACCU, 32'h1);
    frame(CODE_TO_GLOBAL, GP_PERSIST, 8'h00, 32'h0, 8'h00);
    axi_rd(REG_CONFIG);
    chk("persist on", rd[CONFIG_PERSIST_BIT], 1'b1);
    axi_wr(REG_ACCU, acc);
    frame(CODE_TO_COORD, MAX_SLOT, 8'h02, 32'h0, 8'h00);
    chk("nv count", acu_param_sink_inst.nv_cnt, 1);
    chk("nv word", acu_param_sink_inst.nv_last, {2'h2, 5'h14, acc});
    frame(CODE_TO_COORD, 8'h00, 8'h00, 32'h0, 8'h00);
    chk("slot zero", acu_param_sink_inst.nv_cnt, 1);
    frame(CODE_SET_COORD, 8'h00, ALL_MOTORS, 32'h0, 8'h00);
    chk("copy all", acu_param_sink_inst.nv_cnt, 61);
    chk("copy skips zero", acu_param_sink_inst.nv_zero, 0);
    chk("copy last", acu_param_sink_inst.nv_last, {2'h2, 5'h14, acc});
    frame(CODE_SET_COORD, MAX_SLOT, ALL_MOTORS, 32'h0, 8'h00);
    chk("copy one", acu_param_sink_inst.nv_cnt, 64);
    chk("copy one last", acu_param_sink_inst.nv_last, {2'h2, 5'h14, acc});
    frame(CODE_SET_COORD, 8'h03, 8'h01, 32'h0BADF00D, 8'h00);
    chk("set coord nv", acu_param_sink_inst.nv_last, {2'h1, 5'h03, 32'h0BADF00D});
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(REG_CONFIG);
    chk("persist after reset", rd, 0);
    frame(CODE_X_ARITH, 8'h00, 8'h00, 32'h0, 8'h01);
    chk("bad sum", rd[7:0], ST_BAD_SUM);
    complete_run();
  end
endmodule
`default_nettype wire
